// File: gauge_regs.svh
/*
  Register offsets, field positions, reset values and timing counts for
  the host command register bank. Assumes a 100 MHz system clock.
*/
`ifndef GAUGE_REGS_SVH
`define GAUGE_REGS_SVH

`define OFS_TRIGGER 7'h00
`define OFS_MODE 7'h01
`define OFS_RATE_LO 7'h02
`define OFS_RATE_HI 7'h03
`define OFS_TTE_LO 7'h04
`define OFS_TTE_HI 7'h05
`define OFS_TEMP_LO 7'h06
`define OFS_TEMP_HI 7'h07
`define OFS_VOLT_LO 7'h08
`define OFS_VOLT_HI 7'h09

`define TRIGGER_KEY 8'hA9
`define UNMAPPED_READ 8'h00

`define BIT_PIN_DIR 7
`define BIT_PIN_LEVEL 6
`define BIT_CAP_LOAD 5
`define BIT_FULL_CHG 4
`define BIT_PART_RST 3
`define BIT_POR 2
`define BIT_FULL_RST 1
`define BIT_SHIP 0

`define PIN_LEVEL_RST 1'b1
`define PIN_DIR_RST 1'b1
`define POR_FLAG_RST 1'b1

`define CLK_FREQ_HZ 100000000
`define REFRESH_S 2
`define REFRESH_CYCLES (`REFRESH_S * `CLK_FREQ_HZ)

`define VOLT_MAX_MV 16'h1388
`define MIN_PER_HOUR 22'h3C
`define DIV_STEPS 5'h16
`define TTE_SATURATE 16'hFFFF

`endif

// File: gauge_pkg.sv
/*
  Types shared by the host command register bank.
  Assumes gauge_regs.svh supplies the numeric constants.
*/
package gauge_pkg;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } cmd_state_e;
  typedef logic [15:0] word_t;
endpackage

// File: gauge_host_command_registers.sv
/*
  Host-facing low register bank of a battery gauge: command trigger,
  command and pin control, rate input, rate time-to-empty, temperature
  and voltage readouts. Assumes the serial bus engine delivers one-cycle
  byte read and write strobes on clk, and the gauge core supplies the
  samples, the rate capacity and acts on the command pulses.
*/
`include "gauge_regs.svh"

module gauge_host_command_registers #(
  parameter int unsigned REFRESH_CYCLES = `REFRESH_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic gpio_in,
  output logic gpio_out,
  output logic gpio_oe,
  input wire logic pack_cfg_dir,
  input wire logic [15:0] rate_capacity,
  input wire logic [15:0] die_temp_sample,
  input wire logic [15:0] battery_mv_sample,
  input wire logic full_charge_reached,
  output logic capacity_load_cmd,
  output logic [15:0] capacity_load_value,
  output logic full_charge_cmd,
  output logic partial_reset_cmd,
  output logic full_reset_cmd,
  output logic ship_mode_cmd
);

  gauge_pkg::cmd_state_e state;
  gauge_pkg::cmd_state_e next_state;
  logic [7:0] trigger_reg;
  logic [5:0] cmd_bits;
  logic pin_dir;
  logic pin_level;
  logic por_flag;
  logic cfg_load;
  logic gpio_meta;
  logic gpio_sync;
  gauge_pkg::word_t rate_current_value;
  gauge_pkg::word_t rate_time_empty;
  gauge_pkg::word_t die_temp;
  gauge_pkg::word_t battery_volt;
  logic [31:0] tick_cnt;
  logic tick;
  logic div_busy;
  logic div_pending;
  logic [4:0] div_cnt;
  logic [16:0] div_rem;
  logic [21:0] div_quo;
  gauge_pkg::word_t div_den;

  // Address decode
  wire wr_trig = reg_wr && (reg_addr == `OFS_TRIGGER);
  wire wr_mode = reg_wr && (reg_addr == `OFS_MODE);
  wire wr_rate_lo = reg_wr && (reg_addr == `OFS_RATE_LO);
  wire wr_rate_hi = reg_wr && (reg_addr == `OFS_RATE_HI);
  wire key_ok = wr_trig && (reg_wdata == `TRIGGER_KEY) && (state == gauge_pkg::ST_IDLE);
  wire exec = (state == gauge_pkg::ST_EXEC);

  // Priority selection of the single command to run
  wire [5:0] pick;
  assign pick[`BIT_CAP_LOAD] = cmd_bits[`BIT_CAP_LOAD];
  assign pick[`BIT_FULL_CHG] = cmd_bits[`BIT_FULL_CHG] && !cmd_bits[5];
  assign pick[`BIT_PART_RST] = cmd_bits[`BIT_PART_RST] && !(|cmd_bits[5:4]);
  assign pick[`BIT_POR] = 1'b0;
  assign pick[`BIT_FULL_RST] = cmd_bits[`BIT_FULL_RST] && !(|cmd_bits[5:3]);
  assign pick[`BIT_SHIP] = cmd_bits[`BIT_SHIP] && !(|cmd_bits[5:3]) && !cmd_bits[1];
  wire reinit = exec && (pick[`BIT_PART_RST] || pick[`BIT_FULL_RST]);

  // Read mux; pin level reads the pin while it is an input
  wire pin_read = pin_dir ? gpio_sync : pin_level;
  wire [7:0] mode_read = {pin_dir, pin_read, cmd_bits[5:3], por_flag, cmd_bits[1:0]};
  wire [7:0] read_mux =
    (reg_addr == `OFS_TRIGGER) ? trigger_reg :
    (reg_addr == `OFS_MODE) ? mode_read :
    (reg_addr == `OFS_RATE_LO) ? rate_current_value[7:0] :
    (reg_addr == `OFS_RATE_HI) ? rate_current_value[15:8] :
    (reg_addr == `OFS_TTE_LO) ? rate_time_empty[7:0] :
    (reg_addr == `OFS_TTE_HI) ? rate_time_empty[15:8] :
    (reg_addr == `OFS_TEMP_LO) ? die_temp[7:0] :
    (reg_addr == `OFS_TEMP_HI) ? die_temp[15:8] :
    (reg_addr == `OFS_VOLT_LO) ? battery_volt[7:0] :
    (reg_addr == `OFS_VOLT_HI) ? battery_volt[15:8] :
    `UNMAPPED_READ;

  // Refresh and clamp
  wire [15:0] volt_clamped = (battery_mv_sample > `VOLT_MAX_MV) ? `VOLT_MAX_MV
                                                                 : battery_mv_sample;

  // Restoring divider for 60 * capacity / rate
  wire [21:0] numerator = 22'(rate_capacity) * `MIN_PER_HOUR;
  wire [16:0] rem_sh = {div_rem[15:0], div_quo[21]};
  wire fits = rem_sh >= {1'b0, div_den};
  wire [16:0] rem_sub = rem_sh - {1'b0, div_den};
  wire div_last = div_busy && (div_cnt == 5'h01);
  wire div_sat = (div_den == 16'h0000) || (|div_quo[20:15] && div_cnt == 5'h01);
  wire [15:0] quo_done = {div_quo[14:0], fits};
  wire div_start = !div_busy && div_pending;

  always_comb begin
    next_state = state;
    case (state)
      gauge_pkg::ST_IDLE: begin
        if (key_ok) begin
          next_state = gauge_pkg::ST_EXEC;
        end
      end
      gauge_pkg::ST_EXEC: begin
        next_state = gauge_pkg::ST_IDLE;
      end
      default: begin
        next_state = gauge_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= gauge_pkg::ST_IDLE;
      trigger_reg <= 8'h00;
    end else begin
      state <= next_state;
      if (key_ok) begin
        trigger_reg <= reg_wdata;
      end else if (exec) begin
        trigger_reg <= 8'h00;
      end
    end
  end

  // Command bits and power-on flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_bits <= 6'h00;
      por_flag <= `POR_FLAG_RST;
    end else begin
      if (exec) begin
        cmd_bits <= 6'h00;
      end else if (wr_mode) begin
        cmd_bits <= reg_wdata[5:0] & 6'h3B;
      end
      if (full_charge_reached || (exec && pick[`BIT_FULL_CHG])) begin
        por_flag <= 1'b0;
      end else if (wr_mode) begin
        por_flag <= reg_wdata[`BIT_POR];
      end
    end
  end

  // Pin control; direction reloads from the pack configuration
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_dir <= `PIN_DIR_RST;
      pin_level <= `PIN_LEVEL_RST;
      cfg_load <= 1'b1;
    end else if (reinit) begin
      pin_level <= `PIN_LEVEL_RST;
      cfg_load <= 1'b1;
    end else if (cfg_load) begin
      pin_dir <= pack_cfg_dir;
      cfg_load <= 1'b0;
      if (wr_mode) begin
        pin_level <= reg_wdata[`BIT_PIN_LEVEL];
      end
    end else if (wr_mode) begin
      pin_dir <= reg_wdata[`BIT_PIN_DIR];
      pin_level <= reg_wdata[`BIT_PIN_LEVEL];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gpio_meta <= 1'b1;
      gpio_sync <= 1'b1;
      gpio_out <= 1'b0;
      gpio_oe <= 1'b0;
    end else begin
      gpio_meta <= gpio_in;
      gpio_sync <= gpio_meta;
      gpio_out <= 1'b0;
      gpio_oe <= !pin_dir && !pin_level;
    end
  end

  // Command pulses to the gauge core
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      capacity_load_cmd <= 1'b0;
      capacity_load_value <= 16'h0000;
      full_charge_cmd <= 1'b0;
      partial_reset_cmd <= 1'b0;
      full_reset_cmd <= 1'b0;
      ship_mode_cmd <= 1'b0;
    end else begin
      capacity_load_cmd <= exec && pick[`BIT_CAP_LOAD];
      capacity_load_value <= rate_current_value;
      full_charge_cmd <= exec && pick[`BIT_FULL_CHG];
      partial_reset_cmd <= exec && pick[`BIT_PART_RST];
      full_reset_cmd <= exec && pick[`BIT_FULL_RST];
      ship_mode_cmd <= exec && pick[`BIT_SHIP];
    end
  end

  // Rate input, unsigned magnitude of a discharge current
  always_ff @(posedge clk) begin
    if (sys_rst || reinit) begin
      rate_current_value <= 16'h0000;
    end else if (wr_rate_lo) begin
      rate_current_value[7:0] <= reg_wdata;
    end else if (wr_rate_hi) begin
      rate_current_value[15:8] <= reg_wdata;
    end
  end

  // Two second refresh timebase
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_cnt <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == REFRESH_CYCLES - 1);
      tick_cnt <= (tick_cnt == REFRESH_CYCLES - 1) ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
    end
  end

  // Readouts, written only by the refresh
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      die_temp <= 16'h0000;
      battery_volt <= 16'h0000;
    end else if (tick) begin
      die_temp <= die_temp_sample;
      battery_volt <= volt_clamped;
    end
  end

  // Time-to-empty divider, rerun after rate writes and refresh, except those landing in a start cycle
  always_ff @(posedge clk) begin
    if (sys_rst || reinit) begin
      div_pending <= 1'b1;
      div_busy <= 1'b0;
      div_cnt <= 5'h00;
      div_rem <= 17'h0_0000;
      div_quo <= 22'h00_0000;
      div_den <= 16'h0000;
      rate_time_empty <= 16'h0000;
    end else if (div_start) begin
      div_pending <= 1'b0;
      div_busy <= 1'b1;
      div_cnt <= `DIV_STEPS;
      div_rem <= 17'h0_0000;
      div_quo <= numerator;
      div_den <= rate_current_value;
    end else begin
      if (wr_rate_lo || wr_rate_hi || tick) begin
        div_pending <= 1'b1;
      end
      if (div_busy) begin
        div_rem <= fits ? rem_sub : rem_sh;
        div_quo <= {div_quo[20:0], fits};
        div_cnt <= div_cnt - 5'h01;
      end
      if (div_last) begin
        div_busy <= 1'b0;
        rate_time_empty <= div_sat ? `TTE_SATURATE : quo_done;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= read_mux;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  trigger_starts_a: assert property (key_ok |=> exec ##1 !exec)
    else $error("trigger did not execute");
  bad_key_a: assert property (wr_trig && reg_wdata != `TRIGGER_KEY && !exec |=>
    !exec && $stable(cmd_bits)) else $error("bad key acted");
  exec_clears_a: assert property (exec && !wr_mode |=>
    cmd_bits == 6'h00 && trigger_reg == 8'h00) else $error("command bits not cleared");
  priority_one_a: assert property (exec && cmd_bits[5] && cmd_bits[4] |=>
    capacity_load_cmd && !full_charge_cmd) else $error("priority wrong");
  low_priority_a: assert property (exec && cmd_bits == 6'h03 |=>
    full_reset_cmd && !ship_mode_cmd) else $error("reset priority wrong");
  pin_drive_a: assert property (##1 gpio_oe == $past(!pin_dir && !pin_level))
    else $error("pin driver wrong");
  pin_read_a: assert property (reg_rd && reg_addr == `OFS_MODE && pin_dir |=>
    reg_rdata[6] == $past(gpio_sync)) else $error("pin read wrong");
  load_value_a: assert property (capacity_load_cmd |-> $past(exec) &&
    capacity_load_value == $past(rate_current_value)) else $error("load value wrong");
  por_clear_a: assert property (full_charge_reached |=> !por_flag)
    else $error("power-on flag kept");
  volt_cap_a: assert property (battery_volt <= `VOLT_MAX_MV)
    else $error("voltage over limit");
  readonly_a: assert property (!tick |=> $stable(die_temp) && $stable(battery_volt))
    else $error("readout changed");
  empty_trigger_a: assert property (exec && cmd_bits == 6'h00 |=> !(|{capacity_load_cmd,
    full_charge_cmd, partial_reset_cmd, full_reset_cmd, ship_mode_cmd})) else $error("stray cmd");
  div_time_a: assert property (disable iff (sys_rst || reinit)
    div_start |-> ##[22:23] !div_busy) else $error("divider too slow");
  load_run_c: cover property (key_ok ##1 exec && pick[`BIT_CAP_LOAD]);
  ship_run_c: cover property (key_ok ##1 exec && pick[`BIT_SHIP]);
  tte_done_c: cover property (div_last && !div_sat);
  refresh_c: cover property (tick);

endmodule

// File: gauge_host_model.sv
/*
  Host side of the register strobe bus: byte write and read tasks.
  Assumes strobes are taken on the rising clk edge and read data lands one
  cycle later; all bus changes are made at the falling edge.
*/
`include "gauge_regs.svh"

module gauge_host_model (
  input wire logic clk,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Idle address and data show the inverse of the last value
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask

  // Mode first, then the trigger value
  task automatic issue(input logic [7:0] mode, input logic [7:0] key);
    wr(`OFS_MODE, mode);
    wr(`OFS_TRIGGER, key);
  endtask
endmodule

// File: gauge_host_command_registers_tb_top.sv
/*
  Self-checking bench for the host command register bank.
  Assumes the host model above drives the register bus and the bench plays
  the gauge core and the pull-up on the open-drain pin.
*/
`include "gauge_regs.svh"

module gauge_host_command_registers_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, sys_rst, gpio_out, gpio_oe, ext_low, pack_cfg_dir, full_charge_reached;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d, m;
  logic reg_wr, reg_rd;
  logic [15:0] rate_capacity, die_temp_sample, battery_mv_sample, cap_val, w;
  logic [4:0] hits;
  wire [4:0] cmds;
  logic [7:0] cmd_bit [5] = '{8'h20, 8'h10, 8'h08, 8'h02, 8'h01};
  int errors, checked, pulses;
  wire pin = !(gpio_oe || ext_low);

  gauge_host_model u_gauge_host_model (.clk(clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  gauge_host_command_registers #(.REFRESH_CYCLES(50)) u_gauge_host_command_registers (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_in(pin),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pack_cfg_dir(pack_cfg_dir),
    .rate_capacity(rate_capacity), .die_temp_sample(die_temp_sample),
    .battery_mv_sample(battery_mv_sample), .full_charge_reached(full_charge_reached),
    .capacity_load_cmd(cmds[4]), .capacity_load_value(cap_val),
    .full_charge_cmd(cmds[3]), .partial_reset_cmd(cmds[2]),
    .full_reset_cmd(cmds[1]), .ship_mode_cmd(cmds[0]));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Collects command pulses between checks
  always @(posedge clk) begin
    if (|cmds) begin
      hits <= hits | cmds;
      pulses <= pulses + 1;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd16(input logic [6:0] a, output logic [15:0] v);
    u_gauge_host_model.rd(a, v[7:0]);
    u_gauge_host_model.rd(a + 7'h01, v[15:8]);
  endtask

  task automatic fire(input logic [7:0] mode, input logic [7:0] key);
    hits = 5'h00;
    pulses = 0;
    u_gauge_host_model.issue(mode, key);
    repeat (5) @(negedge clk);
  endtask

  task automatic close_out;
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    close_out();
  end

  initial begin
    sys_rst = 1'b1;
    ext_low = 1'b0;
    pack_cfg_dir = 1'b1;
    full_charge_reached = 1'b0;
    rate_capacity = 16'h0064;
    die_temp_sample = 16'h0BB8;
    battery_mv_sample = 16'h1770;
    hits = 5'h00;
    pulses = 0;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    u_gauge_host_model.rd(`OFS_MODE, d);
    chk({8'h00, d}, 16'h00C4);
    u_gauge_host_model.wr(`OFS_RATE_LO, 8'h03);
    u_gauge_host_model.wr(`OFS_RATE_HI, 8'h00);
    repeat (60) @(negedge clk);
    for (int k = 0; k < 2; k++) begin
      rd16(`OFS_TTE_LO, w);
      chk(w, 16'h07D0);
      rd16(`OFS_TEMP_LO, w);
      chk(w, 16'h0BB8);
      rd16(`OFS_VOLT_LO, w);
      chk(w, 16'h1388);
      for (int a = 4; a < 10; a++) u_gauge_host_model.wr(7'(a), 8'hFF);
    end
    u_gauge_host_model.rd(7'h0A, d);
    chk({8'h00, d}, 16'h0000);
    u_gauge_host_model.wr(`OFS_RATE_LO, 8'h34);
    u_gauge_host_model.wr(`OFS_RATE_HI, 8'h12);
    for (int i = 0; i < 5; i++) begin
      m = 8'hC0;
      for (int j = i; j < 5; j++) m = m | cmd_bit[j];
      fire(m, `TRIGGER_KEY);
      if (i == 0) chk(cap_val, 16'h1234);
      chk({11'h000, hits}, {11'h000, 5'h10 >> i});
      chk(16'(pulses), 16'h0001);
      u_gauge_host_model.rd(`OFS_MODE, d);
      chk({8'h00, d & 8'hFB}, 16'h00C0);
    end
    fire(8'hE0, 8'hA8);
    chk({11'h000, hits}, 16'h0000);
    u_gauge_host_model.rd(`OFS_MODE, d);
    chk({8'h00, d & 8'hFB}, 16'h00E0);
    fire(8'hE0, `TRIGGER_KEY);
    chk({11'h000, hits}, 16'h0010);
    fire(8'hC0, `TRIGGER_KEY);
    chk({11'h000, hits}, 16'h0000);
    u_gauge_host_model.rd(`OFS_TRIGGER, d);
    chk({8'h00, d}, 16'h0000);
    u_gauge_host_model.wr(`OFS_MODE, 8'hC4);
    u_gauge_host_model.rd(`OFS_MODE, d);
    chk({15'h0000, d[2]}, 16'h0001);
    @(negedge clk) full_charge_reached = 1'b1;
    @(negedge clk) full_charge_reached = 1'b0;
    u_gauge_host_model.rd(`OFS_MODE, d);
    chk({15'h0000, d[2]}, 16'h0000);
    u_gauge_host_model.wr(`OFS_MODE, 8'h00);
    repeat (3) @(negedge clk);
    chk({14'h0000, gpio_oe, gpio_out}, 16'h0002);
    u_gauge_host_model.rd(`OFS_MODE, d);
    chk({14'h0000, d[7:6]}, 16'h0000);
    u_gauge_host_model.wr(`OFS_MODE, 8'h40);
    repeat (3) @(negedge clk);
    chk({15'h0000, gpio_oe}, 16'h0000);
    u_gauge_host_model.wr(`OFS_MODE, 8'h80);
    ext_low = 1'b1;
    repeat (4) @(negedge clk);
    chk({15'h0000, gpio_oe}, 16'h0000);
    u_gauge_host_model.rd(`OFS_MODE, d);
    chk({14'h0000, d[7:6]}, 16'h0002);
    ext_low = 1'b0;
    repeat (4) @(negedge clk);
    u_gauge_host_model.rd(`OFS_MODE, d);
    chk({14'h0000, d[7:6]}, 16'h0003);
    u_gauge_host_model.wr(`OFS_MODE, 8'hFB);
    pack_cfg_dir = 1'b0;
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    u_gauge_host_model.rd(`OFS_MODE, d);
    chk({8'h00, d}, 16'h0044);
    fire(8'h44, `TRIGGER_KEY);
    chk({11'h000, hits}, 16'h0000);
    close_out();
  end
endmodule
